// ---- bpc_pkg.sv ----
// constants for the converter phase, capacitor and switching-rate register
package bpc_pkg;
   localparam logic [15:0] CFG_OFFSET       = 16'h7813;
   localparam logic [15:0] STATUS_OFFSET    = 16'h7900;
   // field positions (lsb) inside the configuration word
   localparam int          CONV4_PHASE_POS  = 15;
   localparam int          CONV3_PHASE_POS  = 14;
   localparam int          CONV2_PHASE_POS  = 13;
   localparam int          CONV1_PHASE_POS  = 12;
   localparam int          CONV4_CAP_POS    = 10;
   localparam int          CONV3_CAP_POS    = 8;
   localparam int          CONV2_CAP_POS    = 6;
   localparam int          CONV1_CAP_POS    = 4;
   localparam int          CONV2_RATE_POS   = 2;
   localparam int          CONV1_RATE_POS   = 0;
   // values after reset
   localparam logic        CONV4_PHASE_RST  = 1'b0;
   localparam logic        CONV3_PHASE_RST  = 1'b0;
   localparam logic        CONV2_PHASE_RST  = 1'b1;
   localparam logic        CONV1_PHASE_RST  = 1'b0;
   localparam logic [1:0]  CAP_RST          = 2'h0;
   localparam logic [1:0]  RATE_RST         = 2'h0;
   // switching-rate codes
   localparam logic [1:0]  RATE_2MHZ        = 2'h1;
   localparam logic [1:0]  RATE_4MHZ        = 2'h2;
   localparam logic [1:0]  RATE_4MHZ_SMALL  = 2'h3;
   // capacitor codes valid for converter 1; converter 2 accepts only CAP_MID
   localparam logic [1:0]  CAP_SMALL        = 2'h0;
   localparam logic [1:0]  CAP_MID          = 2'h2;
   // status register bit positions
   localparam int          ST_LOADING_POS   = 0;
   localparam int          ST_LOADED_POS    = 1;
   localparam int          ST_EEPROM_POS    = 2;
   localparam int          ST_RESERVED_POS  = 3;
endpackage : bpc_pkg

// ---- bpc_cfg_field.sv ----
// one configuration field with separate host and loader write ports
`timescale 1ns/1ps
module bpc_cfg_field #(
   parameter int         W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clocking
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         clk_en,
   // writes
   input  wire logic         host_we,
   input  wire logic [W-1:0] host_d,
   input  wire logic         load_we,
   input  wire logic [W-1:0] load_d,
   // value
   output logic      [W-1:0] q
);
   // refused at elaboration, a zero-width field has nothing to hold
   if (W < 1) begin : g_bad_width
      $error("field width must be at least one");
   end

   wire logic [W-1:0] next_q = load_we ? load_d : (host_we ? host_d : q);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) q <= RST;
      else if (clk_en) q <= next_q;
   end
endmodule : bpc_cfg_field

// ---- bpc_reg.sv ----
// converter phase, output-capacitor and switching-rate configuration register
`timescale 1ns/1ps
module bpc_reg #(
   parameter int AW = 16
) (
   // clock and reset
   input  wire logic          clock,
   input  wire logic          nrst,
   input  wire logic          clk_en,
   // host register port
   input  wire logic [AW-1:0] addr,
   input  wire logic [15:0]   wdata,
   input  wire logic          wr,
   input  wire logic          rd,
   output logic      [15:0]   rdata,
   // configuration loader
   input  wire logic          load_active,
   input  wire logic          external_eeprom_config_load,
   input  wire logic          load_wr,
   input  wire logic [15:0]   load_data,
   // converter controls
   output logic               conv4_clock_invert,
   output logic               conv3_clock_invert,
   output logic               conv2_clock_invert,
   output logic               conv1_clock_invert,
   output logic      [1:0]    conv4_outcap_range,
   output logic      [1:0]    conv3_outcap_range,
   output logic      [1:0]    conv2_outcap_range,
   output logic      [1:0]    conv1_outcap_range,
   output logic      [1:0]    conv2_switch_rate,
   output logic      [1:0]    conv1_switch_rate,
   // decoded rate selects and reserved-code flag
   output logic               conv2_rate_4mhz,
   output logic               conv1_rate_4mhz,
   output logic               conv1_small_inductor,
   output logic               cfg_code_reserved
);
   // refused at elaboration, the bus must be at least as wide as the 16-bit offset constants
   if (AW < 16) begin : g_bad_aw
      $error("address width must hold the register offsets");
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset release
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire logic        hit_cfg    = addr == AW'(bpc_pkg::CFG_OFFSET);
   wire logic        hit_status = addr == AW'(bpc_pkg::STATUS_OFFSET);
   wire logic        host_we    = wr && hit_cfg;
   // loader writes count only while a load is in progress
   wire logic        load_we    = load_wr && load_active;

   ////////////////////////////////////////////////////////////////////////////
   // phase bits: written by host or loader
   logic             ph4;
   logic             ph3;
   logic             ph2;
   logic             ph1;

   bpc_cfg_field #(.W(1), .RST(bpc_pkg::CONV4_PHASE_RST)) u_ph4 (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .host_we(host_we), .host_d(wdata[bpc_pkg::CONV4_PHASE_POS]),
      .load_we(load_we), .load_d(load_data[bpc_pkg::CONV4_PHASE_POS]),
      .q(ph4));
   bpc_cfg_field #(.W(1), .RST(bpc_pkg::CONV3_PHASE_RST)) u_ph3 (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .host_we(host_we), .host_d(wdata[bpc_pkg::CONV3_PHASE_POS]),
      .load_we(load_we), .load_d(load_data[bpc_pkg::CONV3_PHASE_POS]),
      .q(ph3));
   bpc_cfg_field #(.W(1), .RST(bpc_pkg::CONV2_PHASE_RST)) u_ph2 (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .host_we(host_we), .host_d(wdata[bpc_pkg::CONV2_PHASE_POS]),
      .load_we(load_we), .load_d(load_data[bpc_pkg::CONV2_PHASE_POS]),
      .q(ph2));
   bpc_cfg_field #(.W(1), .RST(bpc_pkg::CONV1_PHASE_RST)) u_ph1 (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .host_we(host_we), .host_d(wdata[bpc_pkg::CONV1_PHASE_POS]),
      .load_we(load_we), .load_d(load_data[bpc_pkg::CONV1_PHASE_POS]),
      .q(ph1));

   ////////////////////////////////////////////////////////////////////////////
   // capacitor and rate fields: loader only, host write port held off
   logic [1:0]       cap4;
   logic [1:0]       cap3;
   logic [1:0]       cap2;
   logic [1:0]       cap1;
   logic [1:0]       rate2;
   logic [1:0]       rate1;

   bpc_cfg_field #(.W(2), .RST(bpc_pkg::CAP_RST)) u_cap4 (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .host_we(1'b0), .host_d(2'h0),
      .load_we(load_we), .load_d(load_data[bpc_pkg::CONV4_CAP_POS +: 2]),
      .q(cap4));
   bpc_cfg_field #(.W(2), .RST(bpc_pkg::CAP_RST)) u_cap3 (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .host_we(1'b0), .host_d(2'h0),
      .load_we(load_we), .load_d(load_data[bpc_pkg::CONV3_CAP_POS +: 2]),
      .q(cap3));
   bpc_cfg_field #(.W(2), .RST(bpc_pkg::CAP_RST)) u_cap2 (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .host_we(1'b0), .host_d(2'h0),
      .load_we(load_we), .load_d(load_data[bpc_pkg::CONV2_CAP_POS +: 2]),
      .q(cap2));
   bpc_cfg_field #(.W(2), .RST(bpc_pkg::CAP_RST)) u_cap1 (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .host_we(1'b0), .host_d(2'h0),
      .load_we(load_we), .load_d(load_data[bpc_pkg::CONV1_CAP_POS +: 2]),
      .q(cap1));
   bpc_cfg_field #(.W(2), .RST(bpc_pkg::RATE_RST)) u_rate2 (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .host_we(1'b0), .host_d(2'h0),
      .load_we(load_we), .load_d(load_data[bpc_pkg::CONV2_RATE_POS +: 2]),
      .q(rate2));
   bpc_cfg_field #(.W(2), .RST(bpc_pkg::RATE_RST)) u_rate1 (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .host_we(1'b0), .host_d(2'h0),
      .load_we(load_we), .load_d(load_data[bpc_pkg::CONV1_RATE_POS +: 2]),
      .q(rate1));

   ////////////////////////////////////////////////////////////////////////////
   // decoded selects and reserved-code watch
   logic             loaded;
   logic             from_eeprom;
   logic             load_prev;
   wire logic [15:0] cfg_word = {ph4, ph3, ph2, ph1, cap4, cap3, cap2, cap1,
                                 rate2, rate1};
   wire logic        next_rate2_4m  = rate2 == bpc_pkg::RATE_4MHZ;
   wire logic        rate2_bad      = rate2 != bpc_pkg::RATE_2MHZ &&
                                      rate2 != bpc_pkg::RATE_4MHZ;
   wire logic        next_rate1_4m  = rate1 == bpc_pkg::RATE_4MHZ ||
                                      rate1 == bpc_pkg::RATE_4MHZ_SMALL;
   wire logic        next_rate1_sm  = rate1 == bpc_pkg::RATE_4MHZ_SMALL;
   wire logic        rate1_bad      = rate1 == bpc_pkg::RATE_RST;
   // reserved codes are flagged, not corrected: the loader owns them
   wire logic        cap2_bad       = cap2 != bpc_pkg::CAP_MID;
   wire logic        cap1_bad       = cap1 != bpc_pkg::CAP_SMALL &&
                                      cap1 != bpc_pkg::CAP_MID;
   // flag only after a load, the all-zero reset state is expected
   wire logic        next_reserved  = loaded &&
                                      (rate2_bad || rate1_bad || cap2_bad || cap1_bad);

   ////////////////////////////////////////////////////////////////////////////
   // load status
   wire logic        load_end       = load_prev && !load_active;
   wire logic        next_loaded    = loaded || load_end;
   wire logic        next_eeprom    = load_active ? external_eeprom_config_load
                                                  : from_eeprom;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         loaded      <= 1'b0;
         from_eeprom <= 1'b0;
         load_prev   <= 1'b0;
      end else if (clk_en) begin
         loaded      <= next_loaded;
         from_eeprom <= next_eeprom;
         load_prev   <= load_active;
      end
   end

   wire logic [15:0] status_word = 16'h0000
                                 | (16'(load_active)   << bpc_pkg::ST_LOADING_POS)
                                 | (16'(loaded)        << bpc_pkg::ST_LOADED_POS)
                                 | (16'(from_eeprom)   << bpc_pkg::ST_EEPROM_POS)
                                 | (16'(next_reserved) << bpc_pkg::ST_RESERVED_POS);

   ////////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe, zero elsewhere
   wire logic [15:0] next_rdata = !rd        ? 16'h0000 :
                                  hit_cfg    ? cfg_word :
                                  hit_status ? status_word : 16'h0000;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) rdata <= 16'h0000;
      else if (clk_en) rdata <= next_rdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs, one cycle behind the stored fields
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         conv4_clock_invert   <= bpc_pkg::CONV4_PHASE_RST;
         conv3_clock_invert   <= bpc_pkg::CONV3_PHASE_RST;
         conv2_clock_invert   <= bpc_pkg::CONV2_PHASE_RST;
         conv1_clock_invert   <= bpc_pkg::CONV1_PHASE_RST;
         conv4_outcap_range   <= bpc_pkg::CAP_RST;
         conv3_outcap_range   <= bpc_pkg::CAP_RST;
         conv2_outcap_range   <= bpc_pkg::CAP_RST;
         conv1_outcap_range   <= bpc_pkg::CAP_RST;
         conv2_switch_rate    <= bpc_pkg::RATE_RST;
         conv1_switch_rate    <= bpc_pkg::RATE_RST;
         conv2_rate_4mhz      <= 1'b0;
         conv1_rate_4mhz      <= 1'b0;
         conv1_small_inductor <= 1'b0;
         cfg_code_reserved    <= 1'b0;
      end else if (clk_en) begin
         conv4_clock_invert   <= ph4;
         conv3_clock_invert   <= ph3;
         conv2_clock_invert   <= ph2;
         conv1_clock_invert   <= ph1;
         conv4_outcap_range   <= cap4;
         conv3_outcap_range   <= cap3;
         conv2_outcap_range   <= cap2;
         conv1_outcap_range   <= cap1;
         conv2_switch_rate    <= rate2;
         conv1_switch_rate    <= rate1;
         conv2_rate_4mhz      <= next_rate2_4m;
         conv1_rate_4mhz      <= next_rate1_4m;
         conv1_small_inductor <= next_rate1_sm;
         cfg_code_reserved    <= next_reserved;
      end
   end
endmodule : bpc_reg

// ---- bpc_reg_monitor.sv ----
// assertion checker for the phase, capacitor and rate register
`timescale 1ns/1ps
module bpc_reg_monitor #(
   parameter int AW = 16
) (
   // clock, reset and host port
   input wire logic          clock,
   input wire logic          nrst,
   input wire logic          clk_en,
   input wire logic          wr,
   input wire logic          rd,
   input wire logic [AW-1:0] addr,
   input wire logic [15:0]   wdata,
   input wire logic [15:0]   rdata,
   // loader
   input wire logic          load_active,
   input wire logic          load_wr,
   input wire logic [15:0]   load_data,
   // converter controls
   input wire logic          conv4_clock_invert,
   input wire logic          conv3_clock_invert,
   input wire logic          conv2_clock_invert,
   input wire logic          conv1_clock_invert,
   input wire logic          conv2_rate_4mhz,
   input wire logic          conv1_rate_4mhz,
   input wire logic          conv1_small_inductor,
   input wire logic [1:0]    conv4_outcap_range,
   input wire logic [1:0]    conv3_outcap_range,
   input wire logic [1:0]    conv2_outcap_range,
   input wire logic [1:0]    conv1_outcap_range,
   input wire logic [1:0]    conv2_switch_rate,
   input wire logic [1:0]    conv1_switch_rate
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   wire [15:0] ctl = {conv4_clock_invert, conv3_clock_invert, conv2_clock_invert,
      conv1_clock_invert, conv4_outcap_range, conv3_outcap_range, conv2_outcap_range,
      conv1_outcap_range, conv2_switch_rate, conv1_switch_rate};
   wire lw = load_active && load_wr && clk_en;
   // loader wins a tie, so a host write counts only without it
   wire hw = wr && clk_en && addr == bpc_pkg::CFG_OFFSET && !lw;
   wire rs = rd && clk_en;
   property p_load; lw ##1 clk_en |-> ##1 ctl == $past(load_data, 2); endproperty
   property p_phase; hw ##1 clk_en |-> ##1 ctl[15:12] == $past(wdata[15:12], 2); endproperty
   property p_ro; $changed(ctl[11:0]) |-> $past(lw, 2); endproperty
   // a frozen clock enable keeps the last read word standing
   property p_idle; rdata != 16'h0000 && $past(clk_en) |-> $past(rs); endproperty
   property p_unmap;
      rs && addr != bpc_pkg::CFG_OFFSET && addr != bpc_pkg::STATUS_OFFSET |=> rdata == 16'h0000;
   endproperty
   property p_rate2; conv2_rate_4mhz == (conv2_switch_rate == bpc_pkg::RATE_4MHZ); endproperty
   property p_rate1; conv1_rate_4mhz == conv1_switch_rate[1]; endproperty
   property p_small;
      conv1_small_inductor == (conv1_switch_rate == bpc_pkg::RATE_4MHZ_SMALL);
   endproperty
   a_load: assert property (p_load) else $error("loaded word not on controls");
   a_phase: assert property (p_phase) else $error("phase write lost");
   a_ro: assert property (p_ro) else $error("cap or rate changed without load");
   a_idle: assert property (p_idle) else $error("read data without read");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_rate2: assert property (p_rate2) else $error("rate2 decode wrong");
   a_rate1: assert property (p_rate1) else $error("rate1 decode wrong");
   a_small: assert property (p_small) else $error("inductor decode wrong");
   c_load: cover property (lw);
   c_hw: cover property (hw);
   c_rd: cover property (rs ##1 rdata != 16'h0000);
endmodule : bpc_reg_monitor

bind bpc_reg bpc_reg_monitor #(.AW(AW)) bpc_reg_monitor_inst (.clock, .nrst, .clk_en, .wr,
   .rd, .addr, .wdata, .rdata, .load_active, .load_wr, .load_data, .conv4_clock_invert,
   .conv3_clock_invert, .conv2_clock_invert, .conv1_clock_invert, .conv2_rate_4mhz,
   .conv1_rate_4mhz, .conv1_small_inductor, .conv4_outcap_range, .conv3_outcap_range,
   .conv2_outcap_range, .conv1_outcap_range, .conv2_switch_rate, .conv1_switch_rate);

// ---- testbench.sv ----
// self-checking bench for the phase, capacitor and rate register
`timescale 1ns/1ps
module testbench;
   logic        clock = 0, nrst = 0, clk_en = 1, wr = 0, rd = 0, rd_q = 0;
   logic        load_active = 0, load_wr = 0, ext = 0, loaded = 0, src = 0;
   logic [15:0] addr = 0, wdata = 0, load_data = 0, model = 16'h2000, d;
   logic [15:0] expq[$];
   wire  [15:0] rdata, ctl;
   wire  [3:0]  dec;
   int          err_total = 0, compares = 0, seed = 51, i;
   localparam logic [15:0] CFG = bpc_pkg::CFG_OFFSET;
   localparam logic [15:0] ST = bpc_pkg::STATUS_OFFSET;
   bpc_reg bpc_reg_inst (.clock, .nrst, .clk_en, .addr, .wdata, .wr, .rd, .rdata,
      .load_active, .external_eeprom_config_load(ext), .load_wr, .load_data,
      .conv4_clock_invert(ctl[15]), .conv3_clock_invert(ctl[14]),
      .conv2_clock_invert(ctl[13]), .conv1_clock_invert(ctl[12]),
      .conv4_outcap_range(ctl[11:10]), .conv3_outcap_range(ctl[9:8]),
      .conv2_outcap_range(ctl[7:6]), .conv1_outcap_range(ctl[5:4]),
      .conv2_switch_rate(ctl[3:2]), .conv1_switch_rate(ctl[1:0]),
      .conv2_rate_4mhz(dec[3]), .conv1_rate_4mhz(dec[2]),
      .conv1_small_inductor(dec[1]), .cfg_code_reserved(dec[0]));
   always #25 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic res(logic [15:0] v);
      return v[3:2] == 2'h0 || v[3:2] == 2'h3 || v[1:0] == 2'h0 || v[7:6] != 2'h2
         || (v[5:4] != 2'h0 && v[5:4] != 2'h2);
   endfunction : res
   task automatic cmp(logic [15:0] got, logic [15:0] exp, string what);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp
   // one bus cycle; the expected read word is noted as the strobe goes out
   task automatic acc(logic en, logic w, logic r, logic [15:0] a, logic [15:0] v);
      clk_en <= en;
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= v;
      if (w && en && a == CFG) model[15:12] = v[15:12];
      if (r && en) expq.push_back(a == CFG ? model : a == ST ?
         {12'h0, res(model) & loaded, src, loaded, 1'b0} : 16'h0000);
      @(posedge clock);
   endtask : acc
   task automatic idle(int n);
      wr <= 0;
      rd <= 0;
      clk_en <= 1;
      repeat (n) @(posedge clock);
   endtask : idle
   task automatic chk;
      @(negedge clock);
      cmp(ctl, model, "controls");
      @(posedge clock);
   endtask : chk
   task automatic tally_and_finish;
      $display("mismatches %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clock) rd_q <= rd && clk_en;
   always @(negedge clock) if (rd_q) cmp(rdata, expq.pop_front(), "read");
   initial begin
      #50000;
      err_total++;
      tally_and_finish;
   end
   initial begin
      repeat (5) @(posedge clock);
      nrst <= 1;
      repeat (3) @(posedge clock);
      cmp(ctl, 16'h2000, "reset controls");
      acc(1, 0, 1, CFG, 0);
      acc(1, 0, 1, ST, 0);
      acc(1, 0, 1, 16'h1234, 0);
      acc(1, 1, 0, CFG, 16'hFFFF);
      acc(1, 0, 1, CFG, 0);
      idle(2);
      chk;
      $display("reset and host write test done");
      for (i = 0; i < 4; i++) begin
         d = 16'($random(seed));
         d[1:0] = 2'(i);
         d[3:2] = i == 2 ? 2'h2 : 2'h1;
         d[7:6] = 2'h2;
         d[4] = 1'b0;
         rd <= 0;
         load_active <= 1;
         load_wr <= 1;
         load_data <= d;
         ext <= i[0];
         @(posedge clock);
         load_wr <= 0;
         @(posedge clock);
         load_active <= 0;
         model = d;
         loaded = 1;
         src = i[0];
         repeat (2) @(posedge clock);
         chk;
         cmp({12'h0, dec}, {12'h0, d[3:2] == 2'h2, d[1], d[1:0] == 2'h3, res(d)}, "decode");
         acc(1, 0, 1, ST, 0);
      end
      idle(1);
      $display("loader test done");
      acc(1, 1, 0, CFG, ~model);
      acc(0, 1, 0, CFG, model);
      acc(1, 1, 0, ST, 16'hFFFF);
      load_wr <= 1;
      acc(1, 0, 1, CFG, 0);
      load_wr <= 0;
      acc(1, 0, 1, CFG, 0);
      acc(1, 0, 1, ST, 0);
      idle(2);
      chk;
      nrst <= 0;
      idle(2);
      nrst <= 1;
      repeat (3) @(posedge clock);
      model = 16'h2000;
      loaded = 0;
      src = 0;
      acc(1, 0, 1, CFG, 0);
      acc(1, 0, 1, ST, 0);
      idle(2);
      chk;
      $display("read-only and second reset test done");
      tally_and_finish;
   end
endmodule : testbench
